// ==== rtl/t1sp_serial_port.sv ====
// Serial host register port of the T1 framer with its register file
`timescale 1ns/1ps
module t1sp_serial_port (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        serial_port_select_i,
  input  wire logic        chip_sel_n_i,
  input  wire logic        serial_clk_i,
  input  wire logic        serial_in_i,
  input  wire logic        hw_framing_sel_i,
  input  wire logic [7:0]  receive_alarm_status_i,
  input  wire logic        bpv_event_i,
  input  wire logic        crc_err_event_i,
  input  wire logic        oof_event_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_o,
  output logic             int_n_o,
  output logic [1:0]       framing_format_o,
  output logic [7:0]       common_ctrl_o,
  output logic [7:0]       rx_ctrl_o,
  output logic [7:0]       tx_ctrl_o,
  output logic [23:0]      tx_idle_o,
  output logic [23:0]      tx_transp_o,
  output logic [23:0]      rx_mark_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic host_s;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic hwfm_s;
  logic sclk_d_r;

  t1sp_sync2 u_sync_sps  (.clk_i(clk_i), .resetn_i(resetn_i),
                          .d_i(serial_port_select_i), .q_o(host_s));
  t1sp_sync2 u_sync_cs   (.clk_i(clk_i), .resetn_i(resetn_i),
                          .d_i(chip_sel_n_i), .q_o(cs_n_s));
  t1sp_sync2 u_sync_sclk (.clk_i(clk_i), .resetn_i(resetn_i),
                          .d_i(serial_clk_i), .q_o(sclk_s));
  t1sp_sync2 u_sync_sdi  (.clk_i(clk_i), .resetn_i(resetn_i),
                          .d_i(serial_in_i), .q_o(sdi_s));
  t1sp_sync2 u_sync_hwfm (.clk_i(clk_i), .resetn_i(resetn_i),
                          .d_i(hw_framing_sel_i), .q_o(hwfm_s));

  // Edges of the host clock only; line clocks never touch this port
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic abort;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  // Hardware mode or deselect kills any access, burst included
  assign abort = ~host_s | cs_n_s;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  t1sp_pkg::t1sp_state_t state_r;
  logic [7:0] shift_r;
  logic [7:0] rd_shift_r;
  logic [2:0] bitcnt_r;
  logic [3:0] addr_r;
  logic       burst_r;
  logic       rd_any_r;
  logic       serial_out_r;
  logic       serial_out_oe_r;

  logic [7:0] in_byte;
  logic       cmd_done;
  logic       cmd_ok;
  logic       wr_en;
  logic [7:0] rd_val;

  // LSB arrives first, so it ends up in bit 0 after eight shifts
  assign in_byte  = {sdi_s, shift_r[7:1]};
  assign cmd_done = (state_r == t1sp_pkg::ST_CMD) && sclk_rise
                    && (bitcnt_r == t1sp_pkg::BIT_LAST);
  assign cmd_ok   = !in_byte[t1sp_pkg::CMD_DS_BIT]
                    && (!in_byte[t1sp_pkg::CMD_BURST_BIT]
                        || (in_byte[t1sp_pkg::CMD_ADDR_MSB:t1sp_pkg::CMD_ADDR_LSB]
                            == t1sp_pkg::ADDR_FIRST));
  assign wr_en    = (state_r == t1sp_pkg::ST_WDATA) && sclk_rise
                    && (bitcnt_r == t1sp_pkg::BIT_LAST);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r  <= t1sp_pkg::ST_IDLE;
      shift_r  <= t1sp_pkg::REG_RESET;
      bitcnt_r <= t1sp_pkg::BIT_FIRST;
      addr_r   <= t1sp_pkg::ADDR_FIRST;
      burst_r  <= 1'b0;
    end else if (abort) begin
      state_r  <= t1sp_pkg::ST_IDLE;
      bitcnt_r <= t1sp_pkg::BIT_FIRST;
    end else begin
      unique case (state_r)
        t1sp_pkg::ST_IDLE: begin
          state_r  <= t1sp_pkg::ST_CMD;
          bitcnt_r <= t1sp_pkg::BIT_FIRST;
        end
        t1sp_pkg::ST_CMD: begin
          if (sclk_rise) begin
            shift_r  <= in_byte;
            bitcnt_r <= bitcnt_r + t1sp_pkg::BIT_ONE;
            if (cmd_done) begin
              addr_r  <= in_byte[t1sp_pkg::CMD_ADDR_MSB:t1sp_pkg::CMD_ADDR_LSB];
              burst_r <= in_byte[t1sp_pkg::CMD_BURST_BIT];
              if (!cmd_ok) begin
                state_r <= t1sp_pkg::ST_IGNORE;
              end else if (in_byte[t1sp_pkg::CMD_RW_BIT]) begin
                state_r <= t1sp_pkg::ST_RDATA;
              end else begin
                state_r <= t1sp_pkg::ST_WDATA;
              end
            end
          end
        end
        t1sp_pkg::ST_WDATA: begin
          if (sclk_rise) begin
            shift_r  <= in_byte;
            bitcnt_r <= bitcnt_r + t1sp_pkg::BIT_ONE;
            if (wr_en) begin
              if (burst_r && addr_r != t1sp_pkg::ADDR_LAST) begin
                addr_r <= addr_r + t1sp_pkg::ADDR_STEP;
              end else begin
                state_r <= t1sp_pkg::ST_IGNORE;
              end
            end
          end
        end
        t1sp_pkg::ST_RDATA: begin
          if (sclk_fall) begin
            if (bitcnt_r == t1sp_pkg::BIT_FIRST && rd_any_r
                && (!burst_r || addr_r == t1sp_pkg::ADDR_LAST)) begin
              state_r <= t1sp_pkg::ST_IGNORE;
            end else begin
              bitcnt_r <= bitcnt_r + t1sp_pkg::BIT_ONE;
              if (bitcnt_r == t1sp_pkg::BIT_LAST && burst_r
                  && addr_r != t1sp_pkg::ADDR_LAST) begin
                addr_r <= addr_r + t1sp_pkg::ADDR_STEP;
              end
            end
          end
        end
        t1sp_pkg::ST_IGNORE: begin
          state_r <= t1sp_pkg::ST_IGNORE;
        end
        default: begin
          state_r <= t1sp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Read shifter; each new byte is fetched at its first falling edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_shift_r   <= t1sp_pkg::REG_RESET;
      rd_any_r     <= 1'b0;
      serial_out_r <= 1'b0;
    end else if (state_r != t1sp_pkg::ST_RDATA || abort) begin
      rd_any_r <= 1'b0;
    end else if (sclk_fall) begin
      if (bitcnt_r == t1sp_pkg::BIT_FIRST) begin
        serial_out_r <= rd_val[0];
        rd_shift_r   <= {1'b0, rd_val[7:1]};
      end else begin
        serial_out_r <= rd_shift_r[0];
        rd_shift_r   <= {1'b0, rd_shift_r[7:1]};
      end
      // Flag only the final byte, or a burst would stop before register 15
      if (bitcnt_r == t1sp_pkg::BIT_LAST
          && (!burst_r || addr_r == t1sp_pkg::ADDR_LAST)) begin
        rd_any_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_out_oe_r <= 1'b0;
    end else begin
      // Released otherwise so a shared line part can drive
      serial_out_oe_r <= (state_r == t1sp_pkg::ST_RDATA) && !abort;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] regs_r [16];
  logic [7:0] status_r;
  logic [7:0] bvc_r;
  logic [7:0] ecr_r;
  logic [7:0] bvc_nxt;
  logic [7:0] ecr_nxt;
  logic       int_n_r;
  logic [1:0] fmt_r;

  always_comb begin
    unique case (addr_r)
      t1sp_pkg::ADDR_STATUS: rd_val = status_r;
      t1sp_pkg::ADDR_BVC:    rd_val = bvc_r;
      t1sp_pkg::ADDR_ECR:    rd_val = ecr_r;
      default:               rd_val = regs_r[addr_r];
    endcase
  end

  // Plain control bytes; status and counters live elsewhere
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 16; i++) begin
        regs_r[i] <= t1sp_pkg::REG_RESET;
      end
    end else if (wr_en && addr_r != t1sp_pkg::ADDR_STATUS
                 && addr_r != t1sp_pkg::ADDR_BVC
                 && addr_r != t1sp_pkg::ADDR_ECR) begin
      regs_r[addr_r] <= in_byte;
    end
  end

  // Preset first, then count: an event in the write cycle is kept
  always_comb begin
    bvc_nxt = (wr_en && addr_r == t1sp_pkg::ADDR_BVC) ? in_byte : bvc_r;
    ecr_nxt = (wr_en && addr_r == t1sp_pkg::ADDR_ECR) ? in_byte : ecr_r;
    if (bpv_event_i && bvc_nxt != t1sp_pkg::BYTE_MAX) begin
      bvc_nxt = bvc_nxt + t1sp_pkg::BYTE_ONE;
    end
    if (crc_err_event_i && ecr_nxt[3:0] != t1sp_pkg::NIB_MAX) begin
      ecr_nxt[3:0] = ecr_nxt[3:0] + t1sp_pkg::NIB_ONE;
    end
    if (oof_event_i && ecr_nxt[7:4] != t1sp_pkg::NIB_MAX) begin
      ecr_nxt[7:4] = ecr_nxt[7:4] + t1sp_pkg::NIB_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bvc_r <= t1sp_pkg::REG_RESET;
      ecr_r <= t1sp_pkg::REG_RESET;
    end else begin
      bvc_r <= bvc_nxt;
      ecr_r <= ecr_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_r <= t1sp_pkg::REG_RESET;
      int_n_r  <= 1'b1;
    end else begin
      status_r <= receive_alarm_status_i;
      int_n_r  <= ~|(status_r & regs_r[t1sp_pkg::ADDR_MASK]);
    end
  end

  // Hardware mode offers only the two basic formats
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fmt_r <= 2'h0;
    end else if (host_s) begin
      fmt_r <= {regs_r[t1sp_pkg::ADDR_CCR][t1sp_pkg::CCR_FM1_BIT],
                regs_r[t1sp_pkg::ADDR_CCR][t1sp_pkg::CCR_FM_BIT]};
    end else begin
      fmt_r <= {1'b0, hwfm_s};
    end
  end

  assign serial_out_o     = serial_out_r;
  assign serial_out_oe_o  = serial_out_oe_r;
  assign int_n_o          = int_n_r;
  assign framing_format_o = fmt_r;
  assign common_ctrl_o    = regs_r[t1sp_pkg::ADDR_CCR];
  assign rx_ctrl_o        = regs_r[t1sp_pkg::ADDR_RCR];
  assign tx_ctrl_o        = regs_r[t1sp_pkg::ADDR_TCR];
  assign tx_idle_o        = {regs_r[t1sp_pkg::ADDR_TIR3], regs_r[t1sp_pkg::ADDR_TIR2],
                             regs_r[t1sp_pkg::ADDR_TIR1]};
  assign tx_transp_o      = {regs_r[t1sp_pkg::ADDR_TTR3], regs_r[t1sp_pkg::ADDR_TTR2],
                             regs_r[t1sp_pkg::ADDR_TTR1]};
  assign rx_mark_o        = {regs_r[t1sp_pkg::ADDR_RMR3], regs_r[t1sp_pkg::ADDR_RMR2],
                             regs_r[t1sp_pkg::ADDR_RMR1]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_HW_MODE_IDLE: assert property (!host_s |=> state_r == t1sp_pkg::ST_IDLE
                                     && !serial_out_oe_o)
    else $error("port active in hardware mode");
  AST_CS_ENDS: assert property (cs_n_s |=> state_r == t1sp_pkg::ST_IDLE)
    else $error("access survived chip select high");
  AST_OUT_ON_FALL: assert property ($changed(serial_out_o) |-> $past(sclk_fall))
    else $error("serial output moved off a falling edge");
  AST_DIR_READ: assert property (cmd_done && cmd_ok && in_byte[0] && !abort
                                 |=> state_r == t1sp_pkg::ST_RDATA)
    else $error("read command not honoured");
  AST_DIR_WRITE: assert property (cmd_done && cmd_ok && !in_byte[0] && !abort
                                  |=> state_r == t1sp_pkg::ST_WDATA)
    else $error("write command not honoured");
  AST_ADDR_TAKEN: assert property (cmd_done && !abort
                                   |=> addr_r == $past(in_byte[4:1]))
    else $error("address field not captured");
  AST_DS_IGNORED: assert property (cmd_done && in_byte[5] && !abort
                                   |=> state_r == t1sp_pkg::ST_IGNORE)
    else $error("command for other device acted on");
  AST_BURST_BAD: assert property (cmd_done && in_byte[7] && in_byte[4:1] != 4'h0
                                  && !abort |=> state_r == t1sp_pkg::ST_IGNORE)
    else $error("burst with nonzero address acted on");
  AST_BURST_STEP: assert property (wr_en && burst_r && addr_r != 4'hF && !abort
                                   |=> addr_r == $past(addr_r) + 4'h1)
    else $error("burst address did not step");
  AST_INT_LOW: assert property ((|(status_r & regs_r[t1sp_pkg::ADDR_MASK]))
                                |=> !int_n_o)
    else $error("unmasked alarm gave no interrupt");
  AST_BURST_RD_ON: assert property (state_r == t1sp_pkg::ST_RDATA && sclk_fall && burst_r
                                    && addr_r != t1sp_pkg::ADDR_LAST && !abort
                                    |=> state_r == t1sp_pkg::ST_RDATA)
    else $error("burst read ended before last register");
  AST_BVC_SAT: assert property (bvc_r == 8'hFF && !wr_en |=> bvc_r == 8'hFF)
    else $error("violation counter wrapped");

  COV_READ: cover property (state_r == t1sp_pkg::ST_RDATA && sclk_fall);
  COV_WRITE: cover property (wr_en && !burst_r);
  COV_BURST_WR: cover property (wr_en && burst_r && addr_r == 4'hF);
  COV_IGNORE: cover property (cmd_done && !cmd_ok);

endmodule // t1sp_serial_port

// ==== inc/t1sp_pkg.sv ====
// Constants, state encoding and behaviour summary of the serial host port
// Operation
// - Serial port works only while the port-select pin is high
// - Port timing comes only from the host serial clock
// - Every access starts with an eight-bit command byte
// - Read data changes on falling serial clock and holds until next fall
// - Command, write data and read data all travel least significant bit first
// - Serial input is sampled on the rising serial clock edge
// - Command bit 0 high means read, low means write
// - Command bits 1 to 4 are the register address, LSB first
// - Command bit 5 high makes the device ignore the command
// - Sixteen control and status registers are reachable through the port
// - Interrupt pin goes low for any unmasked receive alarm
// - Violation, CRC and framing error counters saturate; host may preset them
// - Extended framing formats are selectable only in host mode
// - Command bit 7 selects burst; burst needs address zero or is ignored
// - Burst walks addresses upward; writes to the status register do nothing
// - Chip select rising ends any burst
package t1sp_pkg;

  localparam int unsigned CMD_RW_BIT    = 0;
  localparam int unsigned CMD_ADDR_LSB  = 1;
  localparam int unsigned CMD_ADDR_MSB  = 4;
  localparam int unsigned CMD_DS_BIT    = 5;
  localparam int unsigned CMD_BURST_BIT = 7;

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h1;
  localparam logic [3:0] ADDR_BVC    = 4'h2;
  localparam logic [3:0] ADDR_ECR    = 4'h3;
  localparam logic [3:0] ADDR_CCR    = 4'h4;
  localparam logic [3:0] ADDR_RCR    = 4'h5;
  localparam logic [3:0] ADDR_TCR    = 4'h6;
  localparam logic [3:0] ADDR_TIR1   = 4'h7;
  localparam logic [3:0] ADDR_TIR2   = 4'h8;
  localparam logic [3:0] ADDR_TIR3   = 4'h9;
  localparam logic [3:0] ADDR_TTR1   = 4'hA;
  localparam logic [3:0] ADDR_TTR2   = 4'hB;
  localparam logic [3:0] ADDR_TTR3   = 4'hC;
  localparam logic [3:0] ADDR_RMR1   = 4'hD;
  localparam logic [3:0] ADDR_RMR2   = 4'hE;
  localparam logic [3:0] ADDR_RMR3   = 4'hF;
  localparam logic [3:0] ADDR_FIRST  = 4'h0;
  localparam logic [3:0] ADDR_LAST   = 4'hF;
  localparam logic [3:0] ADDR_STEP   = 4'h1;

  localparam int unsigned CCR_FM_BIT  = 4;
  localparam int unsigned CCR_FM1_BIT = 7;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BYTE_MAX  = 8'hFF;
  localparam logic [3:0] NIB_MAX   = 4'hF;
  localparam logic [7:0] BYTE_ONE  = 8'h01;
  localparam logic [3:0] NIB_ONE   = 4'h1;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_ONE   = 3'h1;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b0_0001,
    ST_CMD    = 5'b0_0010,
    ST_WDATA  = 5'b0_0100,
    ST_RDATA  = 5'b0_1000,
    ST_IGNORE = 5'b1_0000
  } t1sp_state_t;

endpackage

// ==== rtl/t1sp_sync2.sv ====
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module t1sp_sync2 (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule // t1sp_sync2

// ==== testbench/t1sp_host_model.sv ====
// Host controller model that drives the serial control lines of the port
`timescale 1ns/1ps
module t1sp_host_model (
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  // Half of the 200 ns serial clock; clock idles high between frames
  localparam int HALF = 100;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // ----------------------------------------
  // Frame control
  // ----------------------------------------
  task automatic start();
    cs_n_o = 1'b0;
    #(HALF);
  endtask

  task automatic stop();
    #(HALF);
    cs_n_o = 1'b1;
    // Released line must not look like held data
    sdi_o = ~sdi_o;
    #(2 * HALF);
  endtask

  // One byte each way; ok is low if output was not driven or moved
  task automatic xfer(input logic [7:0] wr, output logic [7:0] rd, output logic ok);
    logic early;
    rd = 8'h00;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      // Set while clock is high, so valid over the whole low phase
      sdi_o  = wr[i];
      sclk_o = 1'b0;
      #(HALF);
      sclk_o = 1'b1;
      #10;
      early = sdo_i;
      ok    = ok & sdo_oe_i;
      #(HALF - 20);
      rd[i] = sdo_i;
      ok    = ok & (early === sdo_i);
      #10;
    end
  endtask
endmodule // t1sp_host_model

// ==== testbench/tb_t1_framer_serial_host_port.sv ====
// Self-checking bench for the serial host register port
`timescale 1ns/1ps
module tb_t1_framer_serial_host_port;
  localparam int LIMIT = 20000;

  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic        serial_port_select      = 1'b1;
  logic        hw_fmt   = 1'b0;
  logic [7:0]  status   = 8'h00;
  logic        bpv_ev   = 1'b0;
  logic        crc_ev   = 1'b0;
  logic        oof_ev   = 1'b0;
  logic        cs_n;
  logic        sclk;
  logic        serial_in;
  logic        sdo;
  logic        sdo_oe;
  logic        int_n;
  logic [1:0]  fmt;
  logic [7:0]  cc;
  logic [7:0]  rc;
  logic [7:0]  tc;
  logic [23:0] idle;
  logic [23:0] transp;
  logic [23:0] mark;
  logic [7:0]  exp_r [16] = '{default: 8'h00};
  logic [7:0]  rd;
  logic        ok;
  int          n_tests   = 0;
  int          bad_count = 0;
  int          cycles    = 0;

  always #12.5 clk_i = ~clk_i;

  t1sp_serial_port i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .serial_port_select_i(serial_port_select), .chip_sel_n_i(cs_n),
    .serial_clk_i(sclk), .serial_in_i(serial_in), .hw_framing_sel_i(hw_fmt),
    .receive_alarm_status_i(status), .bpv_event_i(bpv_ev), .crc_err_event_i(crc_ev),
    .oof_event_i(oof_ev), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe), .int_n_o(int_n),
    .framing_format_o(fmt), .common_ctrl_o(cc), .rx_ctrl_o(rc), .tx_ctrl_o(tc),
    .tx_idle_o(idle), .tx_transp_o(transp), .rx_mark_o(mark)
  );

  t1sp_host_model i_host (
    .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(serial_in)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [7:0] cmd(input logic rw, input logic [3:0] a, input logic ds,
                                     input logic bm);
    return {bm, 1'b0, ds, a, rw};
  endfunction

  function automatic logic [7:0] pat(input logic [3:0] a, input logic [3:0] k);
    return {a ^ k, a};
  endfunction

  task automatic access(input logic [7:0] c, input logic [7:0] d, output logic [7:0] r,
                        output logic k);
    logic [7:0] dummy;
    logic       dok;
    i_host.start();
    i_host.xfer(c, dummy, dok);
    i_host.xfer(d, r, k);
    i_host.stop();
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic ds);
    logic [7:0] r;
    logic       k;
    access(cmd(1'b0, a, ds, 1'b0), d, r, k);
  endtask

  task automatic rd_cmp(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic       k;
    access(cmd(1'b1, a, 1'b0, 1'b0), 8'h00, r, k);
    check("read data", {16'h0000, e}, {16'h0000, r});
    check("read hold", 24'h00_0001, {23'h0, k});
  endtask

  task automatic burst(input logic rw, input int n, input logic [3:0] k);
    logic [7:0] r;
    logic       q;
    i_host.start();
    i_host.xfer(cmd(rw, 4'h0, 1'b0, 1'b1), r, q);
    for (int a = 0; a < n; a++) begin
      i_host.xfer(pat(4'(a), k), r, q);
      if (rw) begin
        check("burst data", {16'h0000, exp_r[a]}, {16'h0000, r});
      end else if (a != 0) begin
        exp_r[a] = pat(4'(a), k);
      end
    end
    i_host.stop();
  endtask

  task automatic check_outs(input logic [1:0] f);
    check("framing", {22'h0, f}, {22'h0, fmt});
    check("common", {16'h0000, exp_r[4]}, {16'h0000, cc});
    check("rx ctrl", {16'h0000, exp_r[5]}, {16'h0000, rc});
    check("tx ctrl", {16'h0000, exp_r[6]}, {16'h0000, tc});
    check("idle", {exp_r[9], exp_r[8], exp_r[7]}, idle);
    check("transp", {exp_r[12], exp_r[11], exp_r[10]}, transp);
    check("mark", {exp_r[15], exp_r[14], exp_r[13]}, mark);
  endtask

  task automatic set_status(input logic [7:0] v);
    @(negedge clk_i);
    status   = v;
    exp_r[0] = v;
  endtask

  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(negedge clk_i);
      {oof_ev, crc_ev, bpv_ev} = 3'(1 << which);
      @(negedge clk_i);
      {oof_ev, crc_ev, bpv_ev} = 3'h0;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (5) @(negedge clk_i);
    check("int reset", 24'h00_0001, {23'h0, int_n});
    check("oe reset", 24'h00_0000, {23'h0, sdo_oe});
    check_outs(2'b00);
    for (int a = 1; a < 16; a++) begin
      exp_r[a] = pat(4'(a), 4'hF);
      wr_reg(4'(a), exp_r[a], 1'b0);
    end
    check_outs(2'b11);
    set_status(8'h5A);
    for (int a = 0; a < 16; a++) begin
      rd_cmp(4'(a), exp_r[a]);
    end
    check("int active", 24'h00_0000, {23'h0, int_n});
    set_status(8'h1E);
    repeat (4) @(negedge clk_i);
    check("int masked", 24'h00_0001, {23'h0, int_n});
    wr_reg(4'h0, 8'hFF, 1'b0);
    rd_cmp(4'h0, 8'h1E);
    wr_reg(4'h5, 8'h00, 1'b1);
    check_outs(2'b11);
    access(cmd(1'b1, 4'h5, 1'b1, 1'b0), 8'h00, rd, ok);
    check("other device read", 24'h00_0000, {23'h0, ok});
    access(cmd(1'b0, 4'h1, 1'b0, 1'b1), 8'h00, rd, ok);
    rd_cmp(4'h1, exp_r[1]);
    burst(1'b0, 16, 4'h0);
    check_outs(2'b00);
    burst(1'b1, 16, 4'h0);
    burst(1'b0, 3, 4'h5);
    exp_r[5] = 8'h3C;
    wr_reg(4'h5, exp_r[5], 1'b0);
    rd_cmp(4'h3, exp_r[3]);
    check_outs(2'b00);
    wr_reg(4'h2, 8'hFD, 1'b0);
    pulse(0, 5);
    rd_cmp(4'h2, 8'hFF);
    wr_reg(4'h3, 8'hE1, 1'b0);
    pulse(1, 3);
    pulse(2, 2);
    rd_cmp(4'h3, 8'hF4);
    exp_r[4] = 8'h80;
    wr_reg(4'h4, exp_r[4], 1'b0);
    check_outs(2'b10);
    @(negedge clk_i);
    serial_port_select    = 1'b0;
    hw_fmt = 1'b1;
    repeat (5) @(negedge clk_i);
    wr_reg(4'h6, 8'h00, 1'b0);
    check_outs(2'b01);
    finish_test();
  end
endmodule // tb_t1_framer_serial_host_port
